// ===== logic/ccc_chan_rx.v
// Receive latches for one channel access
`timescale 1ns/1ns
`include "ccc_regs.vh"

module ccc_chan_rx (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Channel side
	input wire [`CCC_RX_W-1:0] pin_i,
	// Coupler side
	input wire [`CCC_RX_W-1:0] clr_i,
	output wire [`CCC_RX_W-1:0] lat_o
);

genvar b;
generate
	for (b = 0; b < `CCC_RX_W; b = b + 1) begin : g_bit
		reg s1_q;
		reg s2_q;
		reg s3_q;
		reg st_q;
		reg lat_q;
		// Three stage sync; a change counts once stages two and three agree
		always @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				st_q <= 1'b0;
				lat_q <= 1'b0;
			end else begin
				s1_q <= pin_i[b];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					st_q <= s3_q;
				end
				// Pulse sets the latch, accept clears it, set wins
				lat_q <= (lat_q & ~clr_i[b]) | (s2_q & s3_q & ~st_q);
			end
		end
		assign lat_o[b] = lat_q;
	end
endgenerate

endmodule

// ===== logic/ccc_chan_tx.v
// Transmit pulse formers for one channel access
`timescale 1ns/1ns
`include "ccc_regs.vh"

module ccc_chan_tx (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Coupler side
	input wire [`CCC_TX_W-1:0] lvl_i,
	input wire stb_i,
	// Channel side
	output wire [`CCC_TX_W-1:0] pls_o
);

genvar b;
generate
	for (b = 0; b < `CCC_TX_W; b = b + 1) begin : g_bit
		reg p_q;
		// One clock pulse only where the level is high at the strobe
		always @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				p_q <= 1'b0;
			end else begin
				p_q <= lvl_i[b] & stb_i;
			end
		end
		assign pls_o[b] = p_q;
	end
endgenerate

endmodule

// ===== logic/ccc_coupler.v
// Channel coupler control: function check, reserve, connect, transfers
`timescale 1ns/1ns
`include "ccc_regs.vh"

// What this block does
// - Act only on functions whose bits 11..9 hold equipment number zero.
// - Reserve only on equipment zero codes 0000 through 0477 octal.
// - Dual access checks autoload 0414 and status 0012; single only autoload.
// - Handle autoload, and status when dual, here; forward all others.
// - Deadman restarts on reserve and subsystem word moves; limit four seconds.
// - Reserve clears on inactive, subsystem inactive or disconnect, clear, expiry.
// - Dual access connects to whichever access first gets a legal function.
// - Other access gets only status replies, with bit 10 set.
// - Nonstatus on unconnected access waits; its inactive or clear drops it.
// - Autoload code starts the autoload sequence toward the control logic.
// - Ready/resume handshakes; format and path come from subsystem writes.
// - 32-bit data register; upper holds even words, lower odd words.
// - Formats six and seven use only the upper half.
// - 12-bit words sit in the top bits of a half.
// - Generate channel parity and check it on function words, disabled by a configuration bit.
// - Four phases of the channel clock time receive, transmit and passes.
// - Receive latch sets on a pulse, cleared after the bit is taken.
// - Transmit pulse only where the level input is high.
module ccc_coupler #(
	parameter DEADMAN_CYC = `CCC_DEAD_S * `CCC_CLK_HZ
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Avalon-MM slave
	input wire [`CCC_AW-1:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output wire [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	output wire irq_o,
	// Channel accesses
	input wire [`CCC_RX_W-1:0] ch0_rx_i,
	input wire [`CCC_RX_W-1:0] ch1_rx_i,
	output wire [`CCC_TX_W-1:0] ch0_tx_o,
	output wire [`CCC_TX_W-1:0] ch1_tx_o,
	// Control logic
	output wire cl_ireq_o,
	output wire [15:0] cl_idata_o,
	input wire cl_irply_i,
	input wire cl_oreq_i,
	input wire [15:0] cl_odata_i,
	output wire cl_orply_o,
	output wire autoload_o
);

// Deadman compare value, cut on purpose to the counter width
localparam [31:0] DM_FULL = DEADMAN_CYC - 1;
localparam [`CCC_DM_W-1:0] DM_LAST = DM_FULL[`CCC_DM_W-1:0];

// ----------------------------------------
// Reset release
// ----------------------------------------
reg rs1_q;
reg rs2_q;
wire rst_n;

// Two stage release of the asynchronous reset
always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		rs1_q <= 1'b0;
		rs2_q <= 1'b0;
	end else begin
		rs1_q <= 1'b1;
		rs2_q <= rs1_q;
	end
end
assign rst_n = rs2_q;

// ----------------------------------------
// State
// ----------------------------------------
reg wait_q;
reg [31:0] rdata_q;
reg irq_q;
reg [`CCC_CTRL_W-1:0] ctrl_q;
reg [`CCC_INT_W-1:0] int_q;
reg [`CCC_INT_W-1:0] mask_q;
reg [3:0] ph_q;
reg rsv_q;
reg [1:0] conn_q;
reg [1:0] pend_q;
reg [23:0] pfn_q;
reg [11:0] fn_q;
reg fsrc_q;
reg fvld_q;
reg auto_q;
reg [31:0] data_q;
reg wsel_q;
reg wrdy_q;
reg half_q;
reg [1:0] snd_q;
reg [27:0] txw_q;
reg [1:0] txv_q;
reg [`CCC_DM_W-1:0] dm_q;
reg ireq_q;
reg [15:0] idata_q;
reg irp_q;
reg orp_q;
reg opq_q;
integer k;

// ----------------------------------------
// Channel receive and transmit
// ----------------------------------------
wire [31:0] rx_pin = {ch1_rx_i, ch0_rx_i};
wire [31:0] rx;
wire [31:0] rx_clr;
wire [27:0] tx_pls;
wire [1:0] en;
wire [1:0] vf;
wire [1:0] eq0;
wire [1:0] inr;
wire [1:0] isal;
wire [1:0] isst;
wire [1:0] blk;
wire [1:0] take;
wire [1:0] hold;
wire [1:0] strep;
wire [1:0] dw;
wire [1:0] inact;
wire [1:0] perr;
wire [23:0] code;

wire dual = ctrl_q[`CCC_CTRL_DUAL];
wire par_en = ctrl_q[`CCC_CTRL_PAR];
wire [3:0] fmt = ctrl_q[`CCC_CTRL_FMT_HI:`CCC_CTRL_FMT_LO];
wire [1:0] path = ctrl_q[`CCC_CTRL_PATH_HI:`CCC_CTRL_PATH_LO];
wire fmt67 = (fmt == `CCC_FMT_6) | (fmt == `CCC_FMT_7);
wire ph_rx = ph_q[0];
wire ph_tx = ph_q[1];
wire ph_snd = ph_q[3];

genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : g_acc
		wire [`CCC_RX_W-1:0] r = rx[g*16 +: 16];
		wire fnew = r[`CCC_RX_FUNC];
		wire [11:0] c = fnew ? r[11:0] : pfn_q[g*12 +: 12];
		wire flag = fnew | r[`CCC_RX_FULL] | r[`CCC_RX_INACT];
		assign en[g] = (g == 0) | dual;
		assign code[g*12 +: 12] = c;
		assign vf[g] = en[g] & ph_rx &
			(fnew | (pend_q[g] & ~conn_q[1-g]));
		assign eq0[g] = (c[`CCC_EQ_HI:`CCC_EQ_LO] == 3'h0);
		assign inr[g] = (c <= `CCC_FN_RSV_MAX);
		assign isal[g] = (c == `CCC_FN_AUTO);
		assign isst[g] = dual & (c == `CCC_FN_STAT);
		// Access one loses a same cycle race to access zero
		if (g == 1) begin : g_b1
			assign blk[g] = conn_q[0] | (take[0] & inr[0]);
		end else begin : g_b0
			assign blk[g] = conn_q[1];
		end
		assign take[g] = vf[g] & eq0[g] & ~isst[g] & ~blk[g];
		assign hold[g] = vf[g] & eq0[g] & ~isst[g] & blk[g];
		assign strep[g] = vf[g] & eq0[g] & isst[g];
		assign dw[g] = en[g] & ph_rx & r[`CCC_RX_FULL] & rsv_q &
			(conn_q[g] | ~dual);
		assign inact[g] = en[g] & ph_rx & r[`CCC_RX_INACT];
		assign perr[g] = par_en & ph_rx & fnew & ~(^r[12:0]);
		// Latches are freed once the receive phase has taken the word
		assign rx_clr[g*16 +: 16] = {16{ph_rx & flag}};

		ccc_chan_rx u_rx (
			.clk_i(clk_i),
			.rst_n_i(rst_n),
			.pin_i(rx_pin[g*16 +: 16]),
			.clr_i(rx_clr[g*16 +: 16]),
			.lat_o(rx[g*16 +: 16])
		);
		ccc_chan_tx u_tx (
			.clk_i(clk_i),
			.rst_n_i(rst_n),
			.lvl_i(txw_q[g*14 +: 14]),
			.stb_i(ph_tx & txv_q[g]),
			.pls_o(tx_pls[g*14 +: 14])
		);
	end
endgenerate

// ----------------------------------------
// Bus decode and events
// ----------------------------------------
wire acc = (avs_read_i | avs_write_i) & ~wait_q;
wire wr = acc & avs_write_i;
wire rd = acc & avs_read_i;
wire wr_ctrl = wr & (avs_address_i == `CCC_REG_CTRL);
wire wr_data = wr & (avs_address_i == `CCC_REG_DATA);
wire wr_mask = wr & (avs_address_i == `CCC_REG_MASK);
wire rd_data = rd & (avs_address_i == `CCC_REG_DATA);
wire mclr = wr_ctrl & avs_writedata_i[`CCC_CMD_MCLR];
wire ss_drop = wr_ctrl & (avs_writedata_i[`CCC_CMD_INACT] |
	avs_writedata_i[`CCC_CMD_DISC]);
wire dm_exp = rsv_q & (dm_q == DM_LAST);
wire own_inact = |(inact & (conn_q | {1'b0, ~dual}));
wire irp_rise = cl_irply_i & ~irp_q;
wire op_rise = cl_oreq_i & ~opq_q;
wire cl_path = (path == `CCC_PATH_CL);
wire sp_path = (path == `CCC_PATH_SP);
wire wd_done = |dw & (fmt67 | wsel_q);
wire [1:0] cix = {conn_q[1], ~conn_q[1]};
wire [31:0] bm = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
	{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
wire [31:0] wmix = (data_q & ~bm) | (avs_writedata_i & bm);
wire dm_kick = |(take & inr) | rd_data | wr_data | irp_rise |
	(op_rise & cl_path);
wire [`CCC_INT_W-1:0] ev;
assign ev[`CCC_INT_FWD] = |(take & ~isal);
assign ev[`CCC_INT_AUTO] = |(take & isal);
assign ev[`CCC_INT_WORD] = wd_done;
assign ev[`CCC_INT_PERR] = |perr;
assign ev[`CCC_INT_DEAD] = dm_exp;

// Read data multiplexer
reg [31:0] rmux;
always @* begin
	rmux = 32'h0;
	case (avs_address_i)
		`CCC_REG_CTRL: rmux[`CCC_CTRL_W-1:0] = ctrl_q;
		`CCC_REG_STAT: rmux[8:0] = {half_q, wrdy_q, auto_q, pend_q,
			conn_q, fvld_q, rsv_q};
		`CCC_REG_FUNC: rmux[13:0] = {fvld_q, fsrc_q, fn_q};
		`CCC_REG_DATA: rmux = data_q;
		`CCC_REG_INT: rmux[`CCC_INT_W-1:0] = int_q;
		`CCC_REG_MASK: rmux[`CCC_INT_W-1:0] = mask_q;
		default: rmux = 32'h0;
	endcase
end

// ----------------------------------------
// Bus slave, interrupt and phase clock
// ----------------------------------------
always @(posedge clk_i or negedge rst_n) begin
	if (!rst_n) begin
		wait_q <= 1'b1;
		rdata_q <= 32'h0;
		irq_q <= 1'b0;
		ctrl_q <= `CCC_CTRL_RST;
		mask_q <= {`CCC_INT_W{1'b0}};
		int_q <= {`CCC_INT_W{1'b0}};
		ph_q <= `CCC_PH_RST;
	end else begin
		// One wait cycle, then the request is taken
		wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
		// Read data only moves on a read, so it holds across writes
		if (avs_read_i & wait_q) begin
			rdata_q <= rmux;
		end
		if (wr_ctrl) begin
			ctrl_q <= wmix[`CCC_CTRL_W-1:0];
		end
		if (wr_mask) begin
			mask_q <= wmix[`CCC_INT_W-1:0];
		end
		// Read clears the sticky bits, a new event wins
		if (rd & (avs_address_i == `CCC_REG_INT)) begin
			int_q <= ev;
		end else begin
			int_q <= int_q | ev;
		end
		irq_q <= |(int_q & mask_q);
		// Receive, transmit, pass-on and pass-back phases
		ph_q <= {ph_q[2:0], ph_q[3]};
	end
end

// ----------------------------------------
// Deadman timer
// ----------------------------------------
always @(posedge clk_i or negedge rst_n) begin
	if (!rst_n) begin
		dm_q <= {`CCC_DM_W{1'b0}};
	end else if (!rsv_q | dm_kick | dm_exp) begin
		dm_q <= {`CCC_DM_W{1'b0}};
	end else begin
		dm_q <= dm_q + 1'b1;
	end
end

// ----------------------------------------
// Function handling, reserve and connect
// ----------------------------------------
always @(posedge clk_i or negedge rst_n) begin
	if (!rst_n) begin
		rsv_q <= 1'b0;
		conn_q <= 2'h0;
		pend_q <= 2'h0;
		pfn_q <= 24'h0;
		fn_q <= 12'h0;
		fsrc_q <= 1'b0;
		fvld_q <= 1'b0;
		auto_q <= 1'b0;
		txw_q <= 28'h0;
		txv_q <= 2'h0;
	end else begin
		if (rd & (avs_address_i == `CCC_REG_FUNC)) begin
			fvld_q <= 1'b0;
		end
		txv_q <= txv_q & ~{2{ph_tx}};
		for (k = 0; k < 2; k = k + 1) begin
			if (take[k]) begin
				pend_q[k] <= 1'b0;
				if (inr[k]) begin
					rsv_q <= 1'b1;
					conn_q[k] <= dual;
				end
				if (isal[k]) begin
					auto_q <= 1'b1;
				end else begin
					fn_q <= code[k*12 +: 12];
					fsrc_q <= k[0];
					fvld_q <= 1'b1;
				end
			end
			if (hold[k]) begin
				pend_q[k] <= 1'b1;
				pfn_q[k*12 +: 12] <= code[k*12 +: 12];
			end
			if (strep[k]) begin
				txw_q[k*14 +: 14] <= {1'b0,
					par_en & ~^{conn_q[1-k], 7'h0, wrdy_q, auto_q, rsv_q},
					1'b0, conn_q[1-k], 7'h0, wrdy_q, auto_q, rsv_q};
				txw_q[k*14 + `CCC_STS_OPP] <= conn_q[1-k];
				txv_q[k] <= 1'b1;
			end
			// Resume to the sender once a data word is taken
			if (dw[k]) begin
				txw_q[k*14 +: 14] <= {1'b1, 13'h0};
				txv_q[k] <= 1'b1;
			end
			// Word to send goes out on the owning access
			if (ph_snd & cix[k] & rsv_q & |snd_q & ~txv_q[k]) begin
				txw_q[k*14 +: 14] <= snd_q[1] ?
					{1'b0, par_en & ~^data_q[`CCC_UP_HI:`CCC_UP_LO],
					data_q[`CCC_UP_HI:`CCC_UP_LO]} :
					{1'b0, par_en & ~^data_q[`CCC_LO_HI:`CCC_LO_LO],
					data_q[`CCC_LO_HI:`CCC_LO_LO]};
				txv_q[k] <= 1'b1;
			end
			if (inact[k]) begin
				pend_q[k] <= 1'b0;
			end
		end
		if (own_inact | ss_drop | dm_exp | mclr) begin
			rsv_q <= 1'b0;
			conn_q <= 2'h0;
			auto_q <= 1'b0;
		end
		if (mclr) begin
			pend_q <= 2'h0;
			fvld_q <= 1'b0;
		end
	end
end

// ----------------------------------------
// Data register and transfer coordination
// ----------------------------------------
always @(posedge clk_i or negedge rst_n) begin
	if (!rst_n) begin
		data_q <= 32'h0;
		wsel_q <= 1'b0;
		wrdy_q <= 1'b0;
		half_q <= 1'b0;
		snd_q <= 2'h0;
		ireq_q <= 1'b0;
		idata_q <= 16'h0;
		irp_q <= 1'b0;
		orp_q <= 1'b0;
		opq_q <= 1'b0;
	end else begin
		irp_q <= cl_irply_i;
		opq_q <= cl_oreq_i;
		// Incoming channel words fill upper half first, lower next
		for (k = 0; k < 2; k = k + 1) begin
			if (dw[k]) begin
				if (fmt67 | ~wsel_q) begin
					data_q[31:16] <= {rx[k*16 +: 12], 4'h0};
				end else begin
					data_q[15:0] <= {rx[k*16 +: 12], 4'h0};
				end
				wsel_q <= ~fmt67 & ~wsel_q;
			end
		end
		if (rd_data & sp_path) begin
			wrdy_q <= 1'b0;
		end
		if (wd_done) begin
			wrdy_q <= 1'b1;
		end
		// Control logic input handshake, one half per request
		if (wrdy_q & cl_path & ~ireq_q & ~irp_q) begin
			ireq_q <= 1'b1;
			idata_q <= half_q ? data_q[15:0] : data_q[31:16];
		end
		if (irp_rise & ireq_q) begin
			ireq_q <= 1'b0;
			if (fmt67 | half_q) begin
				wrdy_q <= wd_done;
				half_q <= 1'b0;
			end else begin
				half_q <= 1'b1;
			end
		end
		// Outgoing words from the bus or the control logic
		if (ph_snd & rsv_q & |snd_q & ~|(txv_q & cix)) begin
			snd_q <= {1'b0, snd_q[1] & snd_q[0]};
		end
		if (wr_data & sp_path) begin
			data_q <= wmix;
			snd_q <= {1'b1, ~fmt67};
		end
		if (op_rise & cl_path) begin
			data_q[31:16] <= cl_odata_i;
			snd_q <= 2'h2;
			orp_q <= 1'b1;
		end else if (!cl_oreq_i) begin
			orp_q <= 1'b0;
		end
		if (mclr) begin
			wsel_q <= 1'b0;
			wrdy_q <= 1'b0;
			half_q <= 1'b0;
			snd_q <= 2'h0;
			ireq_q <= 1'b0;
		end
	end
end

// ----------------------------------------
// Outputs
// ----------------------------------------
assign avs_readdata_o = rdata_q;
assign avs_waitrequest_o = wait_q;
assign irq_o = irq_q;
assign ch0_tx_o = tx_pls[13:0];
assign ch1_tx_o = tx_pls[27:14];
assign cl_ireq_o = ireq_q;
assign cl_idata_o = idata_q;
assign cl_orply_o = orp_q;
assign autoload_o = auto_q;

endmodule

// ===== logic/ccc_regs.vh
// Register map, field positions and constants of the channel coupler
`ifndef CCC_REGS_VH
`define CCC_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CCC_AW 5
`define CCC_REG_CTRL 5'h00
`define CCC_REG_STAT 5'h04
`define CCC_REG_FUNC 5'h08
`define CCC_REG_DATA 5'h0c
`define CCC_REG_INT 5'h10
`define CCC_REG_MASK 5'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CCC_CTRL_DUAL 0
`define CCC_CTRL_PAR 1
`define CCC_CTRL_FMT_LO 2
`define CCC_CTRL_FMT_HI 5
`define CCC_CTRL_PATH_LO 6
`define CCC_CTRL_PATH_HI 7
`define CCC_CTRL_W 8
`define CCC_CTRL_RST 8'h02
`define CCC_CMD_INACT 8
`define CCC_CMD_DISC 9
`define CCC_CMD_MCLR 10

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define CCC_INT_W 5
`define CCC_INT_FWD 0
`define CCC_INT_AUTO 1
`define CCC_INT_WORD 2
`define CCC_INT_PERR 3
`define CCC_INT_DEAD 4

// ----------------------------------------
// Channel word layout
// ----------------------------------------
`define CCC_RX_W 16
`define CCC_RX_PAR 12
`define CCC_RX_FUNC 13
`define CCC_RX_FULL 14
`define CCC_RX_INACT 15
`define CCC_TX_W 14
`define CCC_TX_PAR 12
`define CCC_TX_RPLY 13
`define CCC_EQ_HI 11
`define CCC_EQ_LO 9
`define CCC_STS_OPP 10

// ----------------------------------------
// Function codes (octal 0477, 0414, 0012)
// ----------------------------------------
`define CCC_FN_RSV_MAX 12'h13f
`define CCC_FN_AUTO 12'h10c
`define CCC_FN_STAT 12'h00a

// ----------------------------------------
// Formats, paths, data register halves
// ----------------------------------------
`define CCC_FMT_6 4'h6
`define CCC_FMT_7 4'h7
`define CCC_PATH_SP 2'h0
`define CCC_PATH_CL 2'h1
`define CCC_UP_HI 31
`define CCC_UP_LO 20
`define CCC_LO_HI 15
`define CCC_LO_LO 4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCC_CLK_HZ 10000000
`define CCC_DEAD_S 4
`define CCC_DM_W 26
`define CCC_PH_RST 4'h1

`endif

// ===== tb/ccc_coupler_properties.sv
// Checker of the coupler's bus, channel and control logic ports
`timescale 1ns/1ns
`include "ccc_regs.vh"

module ccc_chk (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Bus
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_readdata_o,
	input wire avs_waitrequest_o,
	input wire irq_o,
	// Channel
	input wire [`CCC_TX_W-1:0] ch0_tx_o,
	// Control logic
	input wire cl_ireq_o,
	input wire [15:0] cl_idata_o,
	input wire cl_irply_i,
	input wire cl_oreq_i,
	input wire cl_orply_o
);
	// Bus transfer taken at this edge
	wire tk = (avs_read_i | avs_write_i) & !avs_waitrequest_o;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	wait_once_a:
	assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	rdata_hold_a:
	assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data moved without a read");
	irq_clear_a:
	assert property ($fell(irq_o) |-> $past(tk) || $past(tk, 2) || $past(tk, 3))
		else $error("irq fell without a bus access");
	tx_space_a:
	assert property (|ch0_tx_o |=> (ch0_tx_o == 14'h0)[*3])
		else $error("channel pulses closer than a phase round");
	orply_rise_a:
	assert property ($rose(cl_oreq_i) |=> cl_orply_o)
		else $error("output reply late");
	orply_drop_a:
	assert property (!cl_oreq_i && cl_orply_o |=> !cl_orply_o)
		else $error("output reply outlived request");
	idata_hold_a:
	assert property (cl_ireq_o ##1 cl_ireq_o |-> $stable(cl_idata_o))
		else $error("input data moved during request");
	ireq_drop_a:
	assert property ($rose(cl_irply_i) && cl_ireq_o |=> !cl_ireq_o)
		else $error("input request kept after reply");

	// Main scenarios reached
	cover property (tk && avs_read_i);
	cover property ($rose(irq_o));
	cover property (cl_ireq_o && cl_irply_i);
endmodule

bind ccc_coupler ccc_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .irq_o(irq_o),
	.avs_waitrequest_o(avs_waitrequest_o), .ch0_tx_o(ch0_tx_o),
	.cl_ireq_o(cl_ireq_o), .cl_idata_o(cl_idata_o), .cl_irply_i(cl_irply_i),
	.cl_oreq_i(cl_oreq_i), .cl_orply_o(cl_orply_o));

// ===== tb/ccc_coupler_tb.sv
// Self-checking bench of the channel coupler control block
`timescale 1ns/1ns
`include "ccc_regs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	fail_count++; $display("Error %s expected %h seen %h", nm, e, g); end end

module ccc_coupler_tb;
	typedef struct {logic [11:0] c; logic [31:0] s, q; logic f;} ccc_row_t;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [4:0] avs_address_i = 5'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o, r;
	logic avs_waitrequest_o, irq_o, cl_ireq_o, cl_orply_o, autoload_o;
	logic [15:0] ch0_rx_i, ch1_rx_i, cl_idata_o;
	logic [13:0] ch0_tx_o, ch1_tx_o;
	logic cl_irply_i = 1'b0;
	logic cl_oreq_i = 1'b0;
	logic [15:0] cl_odata_i = 16'h0;
	int fail_count = 0;
	int n_compared = 0;
	int n;
	// Function word, STAT mask 0x41, INT, forwarded
	ccc_row_t rows[6] = '{'{12'h001, 32'h01, 32'h01, 1'b1},
		'{12'h201, 32'h0, 32'h0, 1'b0}, '{12'h140, 32'h0, 32'h01, 1'b1},
		'{12'h10c, 32'h41, 32'h02, 1'b0}, '{12'he0c, 32'h0, 32'h0, 1'b0},
		'{12'h00a, 32'h01, 32'h01, 1'b1}};
	logic [15:0] exp_in[2] = '{16'h1230, 16'h4560};

	ccc_coupler #(.DEADMAN_CYC(200)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
		.ch0_rx_i(ch0_rx_i), .ch1_rx_i(ch1_rx_i), .ch0_tx_o(ch0_tx_o),
		.ch1_tx_o(ch1_tx_o), .cl_ireq_o(cl_ireq_o), .cl_idata_o(cl_idata_o),
		.cl_irply_i(cl_irply_i), .cl_oreq_i(cl_oreq_i),
		.cl_odata_i(cl_odata_i), .cl_orply_o(cl_orply_o),
		.autoload_o(autoload_o));
	ccc_pp_chan pp0_u (.clk_i(clk_i), .tx_i(ch0_tx_o), .rx_o(ch0_rx_i));
	ccc_pp_chan pp1_u (.clk_i(clk_i), .tx_i(ch1_tx_o), .rx_o(ch1_rx_i));

	// 100 ns clock
	initial forever #50 clk_i = ~clk_i;

	task cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	// One bus transfer, held until waitrequest is sampled low
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		begin
			avs_address_i <= a;
			avs_writedata_i <= d;
			avs_write_i <= w;
			avs_read_i <= !w;
			// Only the watchdog ends a wait that never gets its answer
			do begin
				@(posedge clk_i);
			end while (avs_waitrequest_o !== 1'b0);
			r = avs_readdata_o;
			avs_write_i <= 1'b0;
			avs_read_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask

	task tally_and_finish;
		begin
			$display("Compared %0d mismatches %0d", n_compared, fail_count);
			if (fail_count == 0 && n_compared > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	// Watchdog against a hung handshake
	initial begin
		cyc(20000);
		fail_count++;
		tally_and_finish;
	end

	// Main sequence
	initial begin
		cyc(10);
		`CHK("wait in reset", 1'b1, avs_waitrequest_o)
		rst_n_i <= 1'b1;
		cyc(3);
		bus(0, `CCC_REG_CTRL, 0);
		`CHK("ctrl reset", 32'h02, r)
		bus(0, 5'h18, 0);
		`CHK("unmapped", 32'h0, r)
		bus(1, `CCC_REG_FUNC, 32'h3fff);
		bus(0, `CCC_REG_FUNC, 0);
		`CHK("func ro", 32'h0, r)
		// Functions on access 0, reserve dropped four different ways; the master clear row holds no reserve
		foreach (rows[i]) begin
			pp0_u.send(3'b001, rows[i].c);
			cyc(12);
			bus(0, `CCC_REG_STAT, 0);
			`CHK("stat", rows[i].s, r & 32'h41)
			`CHK("autoload", rows[i].s[6], autoload_o)
			bus(0, `CCC_REG_INT, 0);
			`CHK("int", rows[i].q, r)
			`CHK("irq masked", 1'b0, irq_o)
			bus(0, `CCC_REG_FUNC, 0);
			`CHK("func", rows[i].f ? {2'b10, rows[i].c} : 14'h0,
				r[13:0] & (rows[i].f ? 14'h3fff : 14'h2000))
			if (i % 4 == 3) begin
				pp0_u.send(3'b100, 12'h0);
				cyc(12);
			end else
				bus(1, `CCC_REG_CTRL, 32'h02 | (32'h100 << (i % 4)));
			bus(0, `CCC_REG_STAT, 0);
			`CHK("released", 32'h0, r & 32'h41)
		end
		// Dual access: same-cycle functions, then status on the other side
		bus(1, `CCC_REG_CTRL, 32'h03);
		fork
			pp0_u.send(3'b001, 12'h001);
			pp1_u.send(3'b001, 12'h002);
		join
		cyc(12);
		bus(0, `CCC_REG_STAT, 0);
		`CHK("arbitrate", 4'b1001, r[5:2])
		pp1_u.got.delete();
		pp1_u.send(3'b001, 12'h00a);
		cyc(12);
		`CHK("opposite", 2'b01, {pp1_u.got[0][13], pp1_u.got[0][10]})
		`CHK("parity", ~^pp1_u.got[0][11:0], pp1_u.got[0][12])
		bus(1, `CCC_REG_CTRL, 32'h103);
		cyc(12);
		bus(0, `CCC_REG_STAT, 0);
		`CHK("pending taken", 4'b0010, r[5:2])
		// Deadman expiry raises an unmasked interrupt
		bus(1, `CCC_REG_CTRL, 32'h102);
		bus(0, `CCC_REG_INT, 0);
		bus(1, `CCC_REG_MASK, 32'h10);
		pp0_u.send(3'b001, 12'h001);
		cyc(150);
		bus(0, `CCC_REG_STAT, 0);
		`CHK("still held", 1'b1, r[0])
		cyc(80);
		bus(0, `CCC_REG_STAT, 0);
		`CHK("deadman", 1'b0, r[0])
		`CHK("irq", 1'b1, irq_o)
		bus(0, `CCC_REG_INT, 0);
		`CHK("int dead", 1'b1, r[4])
		cyc(3);
		`CHK("irq clear", 1'b0, irq_o)
		// Bus word out to the channel, format 0 then 6
		for (int f = 0; f < 2; f++) begin
			bus(1, `CCC_REG_CTRL, f ? 32'h1a : 32'h02);
			pp0_u.send(3'b001, 12'h001);
			cyc(12);
			pp0_u.got.delete();
			bus(1, `CCC_REG_DATA, 32'habc05670);
			cyc(20);
			`CHK("tx count", f ? 1 : 2, pp0_u.got.size())
			`CHK("upper", 12'habc, pp0_u.got[0][11:0])
			if (f == 0)
				`CHK("lower", 12'h567, pp0_u.got[1][11:0])
		end
		// Channel words in to the control logic, then one out
		bus(1, `CCC_REG_CTRL, 32'h142);
		pp0_u.send(3'b001, 12'h001);
		cyc(12);
		pp0_u.send(3'b010, 12'h123);
		cyc(4);
		pp0_u.send(3'b010, 12'h456);
		foreach (exp_in[i]) begin
			for (n = 0; n < 60 && cl_ireq_o !== 1'b1; n++)
				@(posedge clk_i);
			`CHK("idata", exp_in[i], cl_idata_o)
			cl_irply_i <= 1'b1;
			cyc(2);
			cl_irply_i <= 1'b0;
			cyc(2);
		end
		pp0_u.got.delete();
		cl_odata_i <= 16'h7890;
		cl_oreq_i <= 1'b1;
		for (n = 0; n < 20 && cl_orply_o !== 1'b1; n++)
			@(posedge clk_i);
		`CHK("orply", 1'b1, cl_orply_o)
		cl_oreq_i <= 1'b0;
		cyc(20);
		`CHK("out word", 12'h789, pp0_u.got[0][11:0])
		// Bad parity function: flagged with parity on, ignored with it off
		pp0_u.bad_par = 1'b1;
		for (int p = 0; p < 2; p++) begin
			bus(1, `CCC_REG_CTRL, p ? 32'h100 : 32'h102);
			bus(0, `CCC_REG_INT, 0);
			pp0_u.send(3'b001, 12'h001);
			cyc(12);
			bus(0, `CCC_REG_INT, 0);
			`CHK("parity error", p ? 1'b0 : 1'b1, r[3])
		end
		pp0_u.bad_par = 1'b0;
		// Reset in mid-run while reserved with parity off
		rst_n_i <= 1'b0;
		cyc(2);
		`CHK("wait in reset again", 1'b1, avs_waitrequest_o)
		rst_n_i <= 1'b1;
		cyc(3);
		bus(0, `CCC_REG_CTRL, 0);
		`CHK("ctrl after reset", 32'h02, r)
		bus(0, `CCC_REG_STAT, 0);
		`CHK("stat after reset", 32'h0, r)
		tally_and_finish;
	end
endmodule

// ===== tb/ccc_pp_chan.sv
// Peripheral processor channel model for one coupler access
`timescale 1ns/1ns
`include "ccc_regs.vh"

module ccc_pp_chan (
	// Clock
	input wire clk_i,
	// Pulses from the coupler
	input wire [`CCC_TX_W-1:0] tx_i,
	// Pulses toward the coupler
	output logic [`CCC_RX_W-1:0] rx_o
);
	logic [`CCC_TX_W-1:0] got[$];
	// Set to send a word with its parity bit inverted
	logic bad_par = 1'b0;

	// No pulse on any line while idle
	initial rx_o = 16'h0;

	// Record every word the coupler pulses out
	always @(posedge clk_i) begin
		if (|tx_i)
			got.push_back(tx_i);
	end

	// Hold a word long enough to be latched, then go quiet
	task send(input logic [2:0] kind, input logic [11:0] w);
		begin
			rx_o <= {kind, (~^w) ^ bad_par, w};
			repeat (4) @(posedge clk_i);
			rx_o <= 16'h0;
		end
	endtask
endmodule
